// ==== addr_decode_pkg.sv ====
// shared constants and types for the system address decoder
package addr_decode_pkg;

    // ==========================================================
    // widths
    localparam int ADDR_W = 16;

    // ==========================================================
    // region bounds
    localparam logic [15:0] IO_LO     = 16'h0000;
    localparam logic [15:0] IO_HI     = 16'h005f;
    localparam logic [15:0] RAM_LO    = 16'h0060;
    localparam logic [15:0] RAM_HI    = 16'h015f;
    localparam logic [15:0] GAP_LO    = 16'h0160;
    localparam logic [15:0] GAP_HI    = 16'hdfff;
    localparam logic [15:0] FLASH_LO  = 16'he000;
    localparam logic [15:0] FLASH_HI  = 16'hfdff;
    localparam logic [15:0] SYS_LO    = 16'hfe00;
    localparam logic [15:0] SYS_HI    = 16'hfe0f;
    localparam logic [15:0] MON_LO    = 16'hfe10;
    localparam logic [15:0] MON_HI    = 16'hff48;
    localparam logic [15:0] HOLE1_LO  = 16'hff49;
    localparam logic [15:0] HOLE1_HI  = 16'hff7d;
    localparam logic [15:0] FTEST_AD  = 16'hff57;
    localparam logic [15:0] FPROT_AD  = 16'hff7e;
    localparam logic [15:0] HOLE2_LO  = 16'hff7f;
    localparam logic [15:0] HOLE2_HI  = 16'hffd1;
    localparam logic [15:0] VEC_LO    = 16'hffd2;
    localparam logic [15:0] VEC_HI    = 16'hffff;
    localparam logic [15:0] WDOG_AD   = 16'hffff;

    // ==========================================================
    // system register page, low nibble of the address
    localparam logic [3:0] SYS_BRK_STAT  = 4'h0;
    localparam logic [3:0] SYS_RST_STAT  = 4'h1;
    localparam logic [3:0] SYS_RSV_2     = 4'h2;
    localparam logic [3:0] SYS_BRK_FLAG  = 4'h3;
    localparam logic [3:0] SYS_RSV_4     = 4'h4;
    localparam logic [3:0] SYS_RSV_5     = 4'h5;
    localparam logic [3:0] SYS_RSV_6     = 4'h6;
    localparam logic [3:0] SYS_RSV_7     = 4'h7;
    localparam logic [3:0] SYS_FL_CTRL   = 4'h8;
    localparam logic [3:0] SYS_UNIMP_9   = 4'h9;
    localparam logic [3:0] SYS_RSV_A     = 4'ha;
    localparam logic [3:0] SYS_UNIMP_B   = 4'hb;
    localparam logic [3:0] SYS_BKPT_HI   = 4'hc;
    localparam logic [3:0] SYS_BKPT_LO   = 4'hd;
    localparam logic [3:0] SYS_BRK_CTRL  = 4'he;
    localparam logic [3:0] SYS_VMON      = 4'hf;

    // ==========================================================
    // decode targets
    typedef enum logic [4:0] {
        T_NONE,
        T_IO,
        T_RAM,
        T_FLASH,
        T_BREAK_STATUS,
        T_RESET_STATUS,
        T_BREAK_FLAG,
        T_FLASH_CTRL,
        T_BKPT_HIGH,
        T_BKPT_LOW,
        T_BREAK_CTRL,
        T_VMON_CTRL,
        T_MON_ROM,
        T_FLASH_TEST,
        T_FLASH_PROT,
        T_VECTOR,
        T_WATCHDOG,
        T_RESERVED
    } target_t;

    // classifier result
    typedef struct packed {
        target_t     tgt;
        logic        unimp;
        logic        read_only;
        logic [15:0] base;
    } class_t;

    // registered access presented to the selected target
    typedef struct packed {
        target_t     tgt;
        logic        rd;
        logic        wr;
        logic [15:0] offset;
    } access_t;

endpackage

// ==== region_classify.sv ====
// combinational address classifier for the 64 kbyte map
`timescale 1ns/1ps
module region_classify (
    input  wire logic [15:0]                 addr_i,
    output addr_decode_pkg::class_t          cls_o
);

    // ==========================================================
    // system page lookup
    function automatic addr_decode_pkg::target_t sys_tgt(
        input logic [3:0] idx
    );
        case (idx)
            addr_decode_pkg::SYS_BRK_STAT: begin
                sys_tgt = addr_decode_pkg::T_BREAK_STATUS;
            end
            addr_decode_pkg::SYS_RST_STAT: begin
                sys_tgt = addr_decode_pkg::T_RESET_STATUS;
            end
            addr_decode_pkg::SYS_BRK_FLAG: begin
                sys_tgt = addr_decode_pkg::T_BREAK_FLAG;
            end
            addr_decode_pkg::SYS_FL_CTRL: begin
                sys_tgt = addr_decode_pkg::T_FLASH_CTRL;
            end
            addr_decode_pkg::SYS_BKPT_HI: begin
                sys_tgt = addr_decode_pkg::T_BKPT_HIGH;
            end
            addr_decode_pkg::SYS_BKPT_LO: begin
                sys_tgt = addr_decode_pkg::T_BKPT_LOW;
            end
            addr_decode_pkg::SYS_BRK_CTRL: begin
                sys_tgt = addr_decode_pkg::T_BREAK_CTRL;
            end
            addr_decode_pkg::SYS_VMON: begin
                sys_tgt = addr_decode_pkg::T_VMON_CTRL;
            end
            addr_decode_pkg::SYS_UNIMP_9,
            addr_decode_pkg::SYS_UNIMP_B: begin
                sys_tgt = addr_decode_pkg::T_NONE;
            end
            default: begin
                sys_tgt = addr_decode_pkg::T_RESERVED;
            end
        endcase
    endfunction

    // ==========================================================
    // priority decode; single locations inside holes come first
    always_comb begin
        cls_o           = '0;
        cls_o.tgt       = addr_decode_pkg::T_NONE;
        cls_o.unimp     = 1'b0;
        cls_o.read_only = 1'b0;
        cls_o.base      = addr_i;
        if (addr_i <= addr_decode_pkg::IO_HI) begin
            cls_o.tgt  = addr_decode_pkg::T_IO;
            cls_o.base = addr_decode_pkg::IO_LO;
        end else if (addr_i <= addr_decode_pkg::RAM_HI) begin
            cls_o.tgt  = addr_decode_pkg::T_RAM;
            cls_o.base = addr_decode_pkg::RAM_LO;
        end else if (addr_i <= addr_decode_pkg::GAP_HI) begin
            cls_o.unimp = 1'b1;
        end else if (addr_i <= addr_decode_pkg::FLASH_HI) begin
            cls_o.tgt  = addr_decode_pkg::T_FLASH;
            cls_o.base = addr_decode_pkg::FLASH_LO;
        end else if (addr_i <= addr_decode_pkg::SYS_HI) begin
            cls_o.tgt   = sys_tgt(addr_i[3:0]);
            cls_o.unimp = (cls_o.tgt == addr_decode_pkg::T_NONE);
        end else if (addr_i <= addr_decode_pkg::MON_HI) begin
            cls_o.tgt       = addr_decode_pkg::T_MON_ROM;
            cls_o.read_only = 1'b1;
            cls_o.base      = addr_decode_pkg::MON_LO;
        end else if (addr_i == addr_decode_pkg::FTEST_AD) begin
            cls_o.tgt = addr_decode_pkg::T_FLASH_TEST;
        end else if (addr_i <= addr_decode_pkg::HOLE1_HI) begin
            cls_o.unimp = 1'b1;
        end else if (addr_i == addr_decode_pkg::FPROT_AD) begin
            cls_o.tgt = addr_decode_pkg::T_FLASH_PROT;
        end else if (addr_i <= addr_decode_pkg::HOLE2_HI) begin
            cls_o.unimp = 1'b1;
        end else begin
            cls_o.tgt       = addr_decode_pkg::T_VECTOR;
            cls_o.read_only = 1'b1;
            cls_o.base      = addr_decode_pkg::VEC_LO;
        end
    end

endmodule

// ==== sys_addr_decoder.sv ====
// registered system address decoder with illegal-address reset request
//
// Summary of operation
// - every 16-bit address falls into exactly one region class.
// - any unimplemented access requests an illegal-address reset.
// - writes to read-only locations other than 0xffff produce no write strobe, nothing changes.
// - reads of implemented space have no side effect; a read of 0xffff never reaches watchdog.
// - 0x0000 to 0x005f selects the i/o register page.
// - ram spans 0x0060-0x015f; 0x0160-0xdfff is unimplemented.
// - 0xe000 to 0xfdff selects the user flash array.
// - 0xfe00-0xfe0f system registers, reserved and unimplemented slots.
// - 0xfe10 to 0xff48 selects the monitor rom.
// - 0xff49-0xff7d unimplemented except flash test control at 0xff57.
// - 0xff7e flash protect; 0xff7f-0xffd1 unimplemented.
// - 0xffd2 to 0xffff selects the vector area.
// - 0xffff reads reset vector low byte; writes go to watchdog control.
// - flash test control decodes at 0xff57, apart from flash control.
`timescale 1ns/1ps
module sys_addr_decoder (
    input  wire logic                        clk_i,
    input  wire logic                        arst_n_i,
    input  wire logic [15:0]                 addr_i,
    input  wire logic                        rd_i,
    input  wire logic                        wr_i,
    output addr_decode_pkg::access_t         acc_o,
    output logic                             illegal_rst_o
);

    // ==========================================================
    // classification
    addr_decode_pkg::class_t  cls;
    addr_decode_pkg::access_t acc_d;
    addr_decode_pkg::access_t acc_q;
    logic                     access;
    logic                     illegal_d;
    logic                     illegal_q;

    region_classify u_classify (
        .addr_i (addr_i),
        .cls_o  (cls)
    );

    assign access = rd_i | wr_i;

    // ==========================================================
    // access steering
    always_comb begin
        acc_d        = '0;
        acc_d.tgt    = addr_decode_pkg::T_NONE;
        acc_d.offset = addr_i - cls.base;
        if (access && !cls.unimp) begin
            acc_d.tgt = cls.tgt;
            acc_d.rd  = rd_i;
            acc_d.wr  = wr_i && !cls.read_only;
            if (addr_i == addr_decode_pkg::WDOG_AD && wr_i) begin
                // write side of the last vector byte is watchdog control
                acc_d.tgt    = addr_decode_pkg::T_WATCHDOG;
                acc_d.wr     = 1'b1;
                acc_d.rd     = 1'b0;
                acc_d.offset = '0;
            end
            // reserved slots take no write strobe; an errant write is dropped
            if (cls.tgt == addr_decode_pkg::T_RESERVED) begin
                acc_d.wr = 1'b0;
            end
        end
    end

    // reserved never counts as unimplemented
    assign illegal_d = access && cls.unimp;

    // ==========================================================
    // output registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            acc_q     <= '0;
        end else begin
            acc_q     <= acc_d;
        end
    end

    // one pulse per offending access cycle
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            illegal_q <= 1'b0;
        end else begin
            illegal_q <= illegal_d;
        end
    end

    assign acc_o         = acc_q;
    assign illegal_rst_o = illegal_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence s_acc(logic [15:0] lo, logic [15:0] hi);
        (rd_i || wr_i) && (addr_i >= lo) && (addr_i <= hi);
    endsequence

    sequence s_wr(logic [15:0] lo, logic [15:0] hi);
        wr_i && !rd_i && (addr_i >= lo) && (addr_i <= hi);
    endsequence

    a_gap_reset: assert property (
        s_acc(16'h0160, 16'hdfff) |=> illegal_rst_o && acc_o.tgt == 5'(0))
        else $error("gap access did not request reset");

    a_reset_cause: assert property (
        illegal_rst_o |-> $past(rd_i || wr_i)
            && acc_o.tgt == addr_decode_pkg::T_NONE && !acc_o.rd && !acc_o.wr)
        else $error("reset pulse without an unimplemented access");

    a_io_page: assert property (
        s_acc(16'h0000, 16'h005f) |=> acc_o.tgt == addr_decode_pkg::T_IO
            && !illegal_rst_o)
        else $error("i/o page not selected");

    a_ram_offset: assert property (
        s_acc(16'h0060, 16'h015f) |=> acc_o.tgt == addr_decode_pkg::T_RAM
            && acc_o.offset == $past(addr_i) - 16'h0060)
        else $error("ram select or offset wrong");

    a_flash_sel: assert property (
        s_acc(16'he000, 16'hfdff) |=> acc_o.tgt == addr_decode_pkg::T_FLASH)
        else $error("flash not selected");

    a_sys_holes: assert property (
        (s_acc(16'hfe09, 16'hfe09) or s_acc(16'hfe0b, 16'hfe0b))
            |=> illegal_rst_o)
        else $error("system page hole did not request reset");

    a_reserved_quiet: assert property (
        s_acc(16'hfe04, 16'hfe07) |=> !illegal_rst_o && !acc_o.wr
            && acc_o.tgt == addr_decode_pkg::T_RESERVED)
        else $error("reserved slot misbehaved");

    a_mon_ro: assert property (
        s_wr(16'hfe10, 16'hff48) |=> acc_o.tgt == addr_decode_pkg::T_MON_ROM
            && !acc_o.wr)
        else $error("monitor rom write not suppressed");

    a_ftest_sel: assert property (
        s_acc(16'hff57, 16'hff57) |=>
            acc_o.tgt == addr_decode_pkg::T_FLASH_TEST && !illegal_rst_o)
        else $error("flash test control not decoded");

    a_hole_reset: assert property (
        (s_acc(16'hff49, 16'hff56) or s_acc(16'hff7f, 16'hffd1))
            |=> illegal_rst_o)
        else $error("upper hole did not request reset");

    a_fprot_sel: assert property (
        s_acc(16'hff7e, 16'hff7e) |=>
            acc_o.tgt == addr_decode_pkg::T_FLASH_PROT)
        else $error("flash protect not decoded");

    a_vector_rd: assert property (
        rd_i && !wr_i && addr_i >= 16'hffd2 |=>
            acc_o.tgt == addr_decode_pkg::T_VECTOR && acc_o.rd && !acc_o.wr)
        else $error("vector read not steered to vector area");

    a_wdog_wr: assert property (
        s_wr(16'hffff, 16'hffff) |=>
            acc_o.tgt == addr_decode_pkg::T_WATCHDOG && acc_o.wr)
        else $error("watchdog write not steered");

    a_idle_quiet: assert property (
        !(rd_i || wr_i) |=> !acc_o.rd && !acc_o.wr && !illegal_rst_o)
        else $error("strobe without access");

    a_brk_status: assert property (
        s_acc(16'hfe00, 16'hfe00) |=>
            acc_o.tgt == addr_decode_pkg::T_BREAK_STATUS && !illegal_rst_o)
        else $error("break status register not decoded");

    a_rst_status: assert property (
        s_acc(16'hfe01, 16'hfe01) |=>
            acc_o.tgt == addr_decode_pkg::T_RESET_STATUS && !illegal_rst_o)
        else $error("reset status register not decoded");

    a_brk_flag: assert property (
        s_acc(16'hfe03, 16'hfe03) |=>
            acc_o.tgt == addr_decode_pkg::T_BREAK_FLAG && !illegal_rst_o)
        else $error("break flag control not decoded");

    a_flash_ctrl: assert property (
        s_acc(16'hfe08, 16'hfe08) |=>
            acc_o.tgt == addr_decode_pkg::T_FLASH_CTRL && !illegal_rst_o)
        else $error("flash control not decoded");

    a_bkpt_high: assert property (
        s_acc(16'hfe0c, 16'hfe0c) |=>
            acc_o.tgt == addr_decode_pkg::T_BKPT_HIGH && !illegal_rst_o)
        else $error("breakpoint high byte not decoded");

    a_bkpt_low: assert property (
        s_acc(16'hfe0d, 16'hfe0d) |=>
            acc_o.tgt == addr_decode_pkg::T_BKPT_LOW && !illegal_rst_o)
        else $error("breakpoint low byte not decoded");

    a_brk_ctrl: assert property (
        s_acc(16'hfe0e, 16'hfe0e) |=>
            acc_o.tgt == addr_decode_pkg::T_BREAK_CTRL && !illegal_rst_o)
        else $error("break control not decoded");

    a_vmon_ctrl: assert property (
        s_acc(16'hfe0f, 16'hfe0f) |=>
            acc_o.tgt == addr_decode_pkg::T_VMON_CTRL && !illegal_rst_o)
        else $error("voltage monitor control not decoded");

    a_reserved_rest: assert property (
        (s_acc(16'hfe02, 16'hfe02) or s_acc(16'hfe0a, 16'hfe0a)) |=>
            acc_o.tgt == addr_decode_pkg::T_RESERVED && !illegal_rst_o)
        else $error("reserved system slot misbehaved");

    a_mon_offset: assert property (
        s_acc(16'hfe10, 16'hff48) |=> acc_o.tgt == addr_decode_pkg::T_MON_ROM
            && acc_o.offset == $past(addr_i) - 16'hfe10 && !illegal_rst_o)
        else $error("monitor rom select or offset wrong");

    a_vec_wr_drop: assert property (
        s_wr(16'hffd2, 16'hfffe) |=>
            acc_o.tgt == addr_decode_pkg::T_VECTOR && !acc_o.wr && !acc_o.rd)
        else $error("vector write not suppressed");

endmodule

// ==== cpu_bus_model.sv ====
// behavioural model of the processor core's address bus
`timescale 1ns/1ps
module cpu_bus_model (
    input  wire logic        clk_i,
    output logic      [15:0] addr_o,
    output logic             rd_o,
    output logic             wr_o
);

    // ==========================================================
    // bus cycle
    initial begin
        addr_o = 16'h0000;
        rd_o   = 1'b0;
        wr_o   = 1'b0;
    end

    // called just after an edge; returns just after the taking edge
    task automatic access(input logic [15:0] a, input logic r, input logic w);
        rd_o   = r;
        wr_o   = w;
        // an idle bus shows no stale address
        addr_o = (r | w) ? a : ~addr_o;
        @(posedge clk_i);
        #1;
    endtask

endmodule

// ==== testbench.sv ====
// self-checking bench for the system address decoder
`timescale 1ns/1ps
module testbench;

    logic                     clk_i;
    logic                     arst_n_i;
    logic              [15:0] addr_i;
    logic                     rd_i;
    logic                     wr_i;
    addr_decode_pkg::access_t acc_o;
    logic                     illegal_rst_o;
    int                       errors;
    int                       n_checks;
    int                       cyc;

    sys_addr_decoder i_dut (
        .clk_i         (clk_i),
        .arst_n_i      (arst_n_i),
        .addr_i        (addr_i),
        .rd_i          (rd_i),
        .wr_i          (wr_i),
        .acc_o         (acc_o),
        .illegal_rst_o (illegal_rst_o)
    );

    cpu_bus_model i_cpu (
        .clk_i  (clk_i),
        .addr_o (addr_i),
        .rd_o   (rd_i),
        .wr_o   (wr_i)
    );

    // ==========================================================
    // expected decode
    function automatic addr_decode_pkg::access_t exp_acc(
        input logic [15:0] a, input logic r, input logic w);
        addr_decode_pkg::access_t e;
        e = '0;
        e.rd = r;
        e.wr = w;
        // single registers report a zero offset
        e.offset = 16'h0000;
        e.tgt = addr_decode_pkg::T_NONE;
        if (a <= 16'h005f) begin
            e.tgt = addr_decode_pkg::T_IO;
            e.offset = a;
        end else if (a <= 16'h015f) begin
            e.tgt = addr_decode_pkg::T_RAM;
            e.offset = a - 16'h0060;
        end else if (a <= 16'hdfff) e.tgt = addr_decode_pkg::T_NONE;
        else if (a <= 16'hfdff) begin
            e.tgt = addr_decode_pkg::T_FLASH;
            e.offset = a - 16'he000;
        end else if (a <= 16'hfe0f) begin
            case (a[3:0])
                4'h0: e.tgt = addr_decode_pkg::T_BREAK_STATUS;
                4'h1: e.tgt = addr_decode_pkg::T_RESET_STATUS;
                4'h3: e.tgt = addr_decode_pkg::T_BREAK_FLAG;
                4'h8: e.tgt = addr_decode_pkg::T_FLASH_CTRL;
                4'hc: e.tgt = addr_decode_pkg::T_BKPT_HIGH;
                4'hd: e.tgt = addr_decode_pkg::T_BKPT_LOW;
                4'he: e.tgt = addr_decode_pkg::T_BREAK_CTRL;
                4'hf: e.tgt = addr_decode_pkg::T_VMON_CTRL;
                4'h9, 4'hb: e.tgt = addr_decode_pkg::T_NONE;
                default: e.tgt = addr_decode_pkg::T_RESERVED;
            endcase
        end else if (a <= 16'hff48) begin
            e.tgt = addr_decode_pkg::T_MON_ROM;
            e.offset = a - 16'hfe10;
            e.wr = 1'b0;
        end else if (a == 16'hff57) e.tgt = addr_decode_pkg::T_FLASH_TEST;
        else if (a == 16'hff7e) e.tgt = addr_decode_pkg::T_FLASH_PROT;
        else if (a <= 16'hffd1) e.tgt = addr_decode_pkg::T_NONE;
        else if (a == 16'hffff && w) begin
            e.tgt = addr_decode_pkg::T_WATCHDOG;
            e.offset = 16'h0000;
        end else begin
            e.tgt = addr_decode_pkg::T_VECTOR;
            e.offset = a - 16'hffd2;
            e.wr = 1'b0;
        end
        if (!(r | w)) e.tgt = addr_decode_pkg::T_NONE;
        if (e.tgt == addr_decode_pkg::T_NONE) begin
            e.rd = 1'b0;
            e.wr = 1'b0;
        end
        return e;
    endfunction

    // ==========================================================
    // compare and access helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic go(input logic [15:0] a, input logic r, input logic w);
        addr_decode_pkg::access_t e;
        logic                     bad;
        logic              [31:0] seen_v;
        logic              [31:0] exp_v;
        e = exp_acc(a, r, w);
        bad = (e.tgt == addr_decode_pkg::T_NONE) && (r | w);
        i_cpu.access(a, r, w);
        seen_v = 32'({acc_o.tgt, acc_o.rd, acc_o.wr});
        exp_v = 32'({e.tgt, e.rd, e.wr});
        chk(seen_v, exp_v);
        if (e.tgt != addr_decode_pkg::T_NONE)
            chk(32'(acc_o.offset), 32'(e.offset));
        chk(32'(illegal_rst_o), 32'(bad));
    endtask

    // ==========================================================
    // scenarios
    task automatic t_edges();
        logic [15:0] tbl [21] = '{16'h0000, 16'h005f, 16'h0060, 16'h015f,
            16'h0160, 16'hdfff, 16'he000, 16'hfdff, 16'hfe10, 16'hff48,
            16'hff49, 16'hff56, 16'hff57, 16'hff58, 16'hff7d, 16'hff7e,
            16'hff7f, 16'hffd1, 16'hffd2, 16'hfffe, 16'hffff};
        foreach (tbl[i]) begin
            go(tbl[i], 1'b1, 1'b0);
            go(tbl[i], 1'b0, 1'b1);
        end
    endtask

    task automatic t_sys();
        logic [15:0] a;
        for (int i = 0; i < 16; i++) begin
            a = 16'hfe00 + 16'(i);
            go(a, 1'b1, 1'b0);
            // reserved slots are left unwritten
            if (!(a[3:0] inside {4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'ha}))
                go(a, 1'b0, 1'b1);
        end
    endtask

    // back to back offenders give one pulse each, idle clears it
    task automatic t_pulse();
        go(16'h0160, 1'b1, 1'b0);
        go(16'hdfff, 1'b0, 1'b1);
        go(16'h0000, 1'b0, 1'b0);
        go(16'hff49, 1'b1, 1'b0);
        go(16'h015f, 1'b1, 1'b0);
    endtask

    task automatic t_reset();
        go(16'h1000, 1'b1, 1'b0);
        arst_n_i = 1'b0;
        #1;
        chk(32'(acc_o), 32'h0);
        chk(32'(illegal_rst_o), 32'h0);
        // an offending access under reset must not pulse
        i_cpu.access(16'h1000, 1'b1, 1'b0);
        chk(32'(illegal_rst_o), 32'h0);
        chk(32'(acc_o), 32'h0);
        arst_n_i = 1'b1;
        go(16'h0070, 1'b1, 1'b0);
        go(16'h0000, 1'b0, 1'b0);
    endtask

    // ==========================================================
    // clock, reset, run control
    task automatic complete_run();
        if (errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // whole run is about 80 cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            complete_run();
        end
    end

    initial begin
        arst_n_i = 1'b0;
        errors = 0;
        n_checks = 0;
        cyc = 0;
        repeat (5) @(posedge clk_i);
        #1;
        arst_n_i = 1'b1;
        t_edges();
        t_sys();
        t_pulse();
        t_reset();
        complete_run();
    end

endmodule
